// ---- verilog/pca_regs_pkg.sv ----
// constants shared by the counter array register block and its sub-units.
// assumes an 8-bit special-function-register space with single-cycle strobes.
package pca_regs_pkg;

   localparam int BYTE_W = 8;
   localparam int COUNT_W = 16;
   localparam int NUM_CHANNELS = 6;
   // module that doubles as the watchdog timer
   localparam int WATCHDOG_CHANNEL = 5;

   ////////////////////////////////////////////////////////////////////////////
   // register addresses
   localparam logic [7:0] ADDR_COUNTER_LOW = 8'hF9;
   localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hFA;
   // capture low / high byte per module, module 0 in the lowest byte
   localparam logic [47:0] CAP_LOW_ADDRS = {8'hD2, 8'hFD, 8'hED, 8'hEB, 8'hE9, 8'hFB};
   localparam logic [47:0] CAP_HIGH_ADDRS = {8'hD3, 8'hFE, 8'hEE, 8'hEC, 8'hEA, 8'hFC};

   ////////////////////////////////////////////////////////////////////////////
   // reset values and fixed codes
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [15:0] COUNT_STEP = 16'h0001;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic ECOM_RESET = 1'b0;

endpackage

// ---- verilog/array_counter_unit.sv ----
// 16-bit array counter with its high-byte snapshot.
// assumes write and snapshot strobes are single-cycle and already decoded.
`timescale 1ns/1ps

module array_counter_unit (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic run_i,
   input wire logic wr_low_i,
   input wire logic wr_high_i,
   input wire logic [7:0] wr_data_i,
   input wire logic lock_i,
   input wire logic snap_i,
   output logic [15:0] count_o,
   output logic [7:0] snapshot_o
);

   typedef struct packed {
      logic [15:0] count;
      logic [7:0] snap;
   } cnt_s;

   cnt_s state_reg;
   cnt_s state_next;

   always_comb begin
      state_next = state_reg;
      if (wr_low_i && !lock_i) begin
         state_next.count = {state_reg.count[15:8], wr_data_i};
      end else if (wr_high_i && !lock_i) begin
         state_next.count = {wr_data_i, state_reg.count[7:0]};
      end else if (run_i) begin
         state_next.count = state_reg.count + pca_regs_pkg::COUNT_STEP;
      end
      if (snap_i) begin
         state_next.snap = state_reg.count[15:8];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_reg <= '{count: pca_regs_pkg::RESET_WORD, snap: pca_regs_pkg::RESET_BYTE};
      end else begin
         state_reg <= state_next;
      end
   end

   assign count_o = state_reg.count;
   assign snapshot_o = state_reg.snap;

endmodule

// ---- verilog/capture_channel.sv ----
// one capture/compare module: value, auto-reload value, comparator enable.
// assumes single-cycle decoded write strobes for its own two byte addresses.
`timescale 1ns/1ps

module capture_channel (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic wr_low_i,
   input wire logic wr_high_i,
   input wire logic [7:0] wr_data_i,
   input wire logic reload_sel_i,
   input wire logic lock_i,
   input wire logic [15:0] counter_i,
   output logic [15:0] cap_value_o,
   output logic [15:0] reload_value_o,
   output logic ecom_o,
   output logic match_o
);

   typedef struct packed {
      logic [15:0] cap;
      logic [15:0] reload;
      logic ecom;
      logic match;
   } chan_s;

   chan_s state_reg;
   chan_s state_next;

   always_comb begin
      state_next = state_reg;
      if (wr_low_i) begin
         if (reload_sel_i) begin
            state_next.reload[7:0] = wr_data_i;
         end else begin
            state_next.cap[7:0] = wr_data_i;
         end
         if (!lock_i) begin
            state_next.ecom = 1'b0;
         end
      end
      if (wr_high_i) begin
         if (reload_sel_i) begin
            state_next.reload[15:8] = wr_data_i;
         end else begin
            state_next.cap[15:8] = wr_data_i;
         end
         if (!lock_i) begin
            state_next.ecom = 1'b1;
         end
      end
      state_next.match = state_reg.ecom && (counter_i == state_reg.cap);
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_reg <= '{cap: pca_regs_pkg::RESET_WORD, reload: pca_regs_pkg::RESET_WORD,
                        ecom: pca_regs_pkg::ECOM_RESET, match: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign cap_value_o = state_reg.cap;
   assign reload_value_o = state_reg.reload;
   assign ecom_o = state_reg.ecom;
   assign match_o = state_reg.match;

endmodule

// ---- verilog/pca_counter_capture_regs.sv ----
// register side of the programmable counter array: counter bytes,
// six capture/compare modules and the read path of the register space.
// assumes the processor drives one-cycle read/write strobes with a stable address.
`timescale 1ns/1ps

// Notes on behaviour
// - high byte reads return the latched snapshot
// - watchdog enabled blocks counter high writes
// - capture low byte holds bits 7:0
// - capture high byte holds bits 15:8
// - reload select redirects both capture bytes
// - low byte write clears comparator enable
// - high byte write sets comparator enable
// - watchdog locks counter low, module five mode
// - counter low byte read/write, reset zero
// - comparator enable activates compare against counter
module pca_counter_capture_regs (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic watchdog_enable_i,
   input wire logic auto_reload_select_i,
   input wire logic count_run_i,
   output logic [7:0] sfr_rdata_o,
   output logic sfr_rvalid_o,
   output logic [15:0] array_counter_o,
   output logic [5:0] comparator_function_enable_o,
   output logic [5:0] match_o,
   output logic [95:0] reload_value_o
);

   typedef struct packed {
      logic [7:0] rd_data;
      logic rd_valid;
   } rd_s;

   rd_s state_reg;
   rd_s state_next;

   logic counter_low_hit;
   logic counter_high_hit;
   logic [5:0] cap_low_hit;
   logic [5:0] cap_high_hit;
   logic [15:0] count;
   logic [7:0] snapshot;
   logic [95:0] cap_values;
   logic [95:0] reload_values;
   logic [5:0] ecom;
   logic [5:0] match;

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   assign counter_low_hit = (sfr_addr_i == pca_regs_pkg::ADDR_COUNTER_LOW);
   assign counter_high_hit = (sfr_addr_i == pca_regs_pkg::ADDR_COUNTER_HIGH);

   ////////////////////////////////////////////////////////////////////////////
   // counter

   array_counter_unit i_array_counter_unit (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .run_i(count_run_i),
      .wr_low_i(sfr_wr_i && counter_low_hit),
      .wr_high_i(sfr_wr_i && counter_high_hit),
      .wr_data_i(sfr_wdata_i),
      .lock_i(watchdog_enable_i),
      .snap_i(sfr_rd_i && counter_low_hit),
      .count_o(count),
      .snapshot_o(snapshot)
   );

   ////////////////////////////////////////////////////////////////////////////
   // capture/compare modules

   genvar gi;
   generate
      for (gi = 0; gi < pca_regs_pkg::NUM_CHANNELS; gi++) begin : g_chan
         assign cap_low_hit[gi] = (sfr_addr_i == pca_regs_pkg::CAP_LOW_ADDRS[gi*8 +: 8]);
         assign cap_high_hit[gi] = (sfr_addr_i == pca_regs_pkg::CAP_HIGH_ADDRS[gi*8 +: 8]);

         capture_channel i_capture_channel (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .wr_low_i(sfr_wr_i && cap_low_hit[gi]),
            .wr_high_i(sfr_wr_i && cap_high_hit[gi]),
            .wr_data_i(sfr_wdata_i),
            .reload_sel_i(auto_reload_select_i),
            .lock_i(watchdog_enable_i && (gi == pca_regs_pkg::WATCHDOG_CHANNEL)),
            .counter_i(count),
            .cap_value_o(cap_values[gi*16 +: 16]),
            .reload_value_o(reload_values[gi*16 +: 16]),
            .ecom_o(ecom[gi]),
            .match_o(match[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // read path: data leaves a register one cycle after the strobe

   always_comb begin
      state_next.rd_valid = sfr_rd_i;
      state_next.rd_data = state_reg.rd_data;
      if (sfr_rd_i) begin
         if (counter_low_hit) begin
            state_next.rd_data = count[7:0];
         end else if (counter_high_hit) begin
            state_next.rd_data = snapshot;
         end else begin
            state_next.rd_data = pca_regs_pkg::UNMAPPED_READ;
            for (int i = 0; i < pca_regs_pkg::NUM_CHANNELS; i++) begin
               // the reload select steers reads the same way as writes
               if (cap_low_hit[i]) begin
                  state_next.rd_data = auto_reload_select_i ? reload_values[i*16 +: 8]
                                                            : cap_values[i*16 +: 8];
               end else if (cap_high_hit[i]) begin
                  state_next.rd_data = auto_reload_select_i ? reload_values[i*16+8 +: 8]
                                                            : cap_values[i*16+8 +: 8];
               end
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_reg <= '{rd_data: pca_regs_pkg::RESET_BYTE, rd_valid: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign sfr_rdata_o = state_reg.rd_data;
   assign sfr_rvalid_o = state_reg.rd_valid;
   assign array_counter_o = count;
   assign comparator_function_enable_o = ecom;
   assign match_o = match;
   assign reload_value_o = reload_values;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_snap_on_low: assert property (
      @(posedge clk_i) disable iff (srst_i)
      sfr_rd_i && counter_low_hit |=> snapshot == $past(count[15:8]))
      else $error("snapshot not loaded from counter at low byte read");

   a_high_read_shadow: assert property (
      @(posedge clk_i) disable iff (srst_i)
      sfr_rd_i && counter_high_hit |=> sfr_rvalid_o && sfr_rdata_o == $past(snapshot))
      else $error("high byte read did not return the snapshot");

   a_snap_held: assert property (
      @(posedge clk_i) disable iff (srst_i)
      !(sfr_rd_i && counter_low_hit) |=> $stable(snapshot))
      else $error("snapshot changed without a low byte read");

   a_high_wr_locked: assert property (
      @(posedge clk_i) disable iff (srst_i)
      sfr_wr_i && counter_high_hit && watchdog_enable_i && !count_run_i |=> $stable(count))
      else $error("counter high byte changed while watchdog enabled");

   a_low_wr_locked: assert property (
      @(posedge clk_i) disable iff (srst_i)
      sfr_wr_i && counter_low_hit && watchdog_enable_i && !count_run_i |=> $stable(count))
      else $error("counter low byte changed while watchdog enabled");

   a_low_wr_value: assert property (
      @(posedge clk_i) disable iff (srst_i)
      sfr_wr_i && counter_low_hit && !watchdog_enable_i |=>
         count[7:0] == $past(sfr_wdata_i) && count[15:8] == $past(count[15:8]))
      else $error("counter low byte write not stored");

   a_cap_reset_zero: assert property (
      @(posedge clk_i)
      srst_i |=> cap_values[7:0] == pca_regs_pkg::RESET_BYTE && cap_values[15:8] == pca_regs_pkg::RESET_BYTE)
      else $error("capture value not zero after reset");

   a_cap_high_write: assert property (
      @(posedge clk_i) disable iff (srst_i)
      sfr_wr_i && cap_high_hit[0] && !auto_reload_select_i |=>
         cap_values[15:8] == $past(sfr_wdata_i) && cap_values[7:0] == $past(cap_values[7:0]))
      else $error("capture high byte write not stored in bits 15:8");

   a_reload_redirect: assert property (
      @(posedge clk_i) disable iff (srst_i)
      sfr_wr_i && cap_low_hit[0] && auto_reload_select_i |=>
         reload_values[7:0] == $past(sfr_wdata_i) && cap_values[15:0] == $past(cap_values[15:0]))
      else $error("reload select did not redirect the low byte write");

   a_low_clears_ecom: assert property (
      @(posedge clk_i) disable iff (srst_i)
      sfr_wr_i && cap_low_hit[0] |=> !ecom[0])
      else $error("low byte write did not clear comparator enable");

   a_high_sets_ecom: assert property (
      @(posedge clk_i) disable iff (srst_i)
      sfr_wr_i && cap_high_hit[0] |=> ecom[0])
      else $error("high byte write did not set comparator enable");

   a_wd_mode_locked: assert property (
      @(posedge clk_i) disable iff (srst_i)
      watchdog_enable_i && sfr_wr_i && (cap_low_hit[5] || cap_high_hit[5]) |=> $stable(ecom[5]))
      else $error("module five enable changed while watchdog enabled");

   a_match_gated: assert property (
      @(posedge clk_i) disable iff (srst_i)
      ecom[0] && count == cap_values[15:0] |=> match[0])
      else $error("enabled comparator missed a counter match");

   a_no_match_off: assert property (
      @(posedge clk_i) disable iff (srst_i)
      !ecom[0] |=> !match[0])
      else $error("disabled comparator reported a match");

   a_low_read_value: assert property (
      @(posedge clk_i) disable iff (srst_i)
      sfr_rd_i && counter_low_hit |=> sfr_rvalid_o && sfr_rdata_o == $past(count[7:0]))
      else $error("counter low byte read returned the wrong value");

   a_high_wr_value: assert property (
      @(posedge clk_i) disable iff (srst_i)
      sfr_wr_i && counter_high_hit && !watchdog_enable_i |=>
         count[15:8] == $past(sfr_wdata_i) && count[7:0] == $past(count[7:0]))
      else $error("counter high byte write not stored while unlocked");

   a_count_step: assert property (
      @(posedge clk_i) disable iff (srst_i)
      count_run_i && !(sfr_wr_i && !watchdog_enable_i && (counter_low_hit || counter_high_hit)) |=>
         count == $past(count) + pca_regs_pkg::COUNT_STEP)
      else $error("running counter did not step by one");

   a_count_idle: assert property (
      @(posedge clk_i) disable iff (srst_i)
      !count_run_i && !(sfr_wr_i && !watchdog_enable_i && (counter_low_hit || counter_high_hit)) |=>
         $stable(count))
      else $error("stopped counter changed without a write");

   a_counter_reset: assert property (
      @(posedge clk_i)
      srst_i |=> count == pca_regs_pkg::RESET_WORD && snapshot == pca_regs_pkg::RESET_BYTE)
      else $error("counter or snapshot not zero after reset");

   // every module gets the same byte, enable and compare checks
   genvar gc;
   generate
      for (gc = 0; gc < pca_regs_pkg::NUM_CHANNELS; gc++) begin : g_chan_chk
         a_cap_low_write: assert property (
            @(posedge clk_i) disable iff (srst_i)
            sfr_wr_i && cap_low_hit[gc] && !auto_reload_select_i |=>
               cap_values[gc*16 +: 8] == $past(sfr_wdata_i))
            else $error("capture low byte write not stored");

         a_cap_low_read: assert property (
            @(posedge clk_i) disable iff (srst_i)
            sfr_rd_i && cap_low_hit[gc] && !auto_reload_select_i |=>
               sfr_rdata_o == $past(cap_values[gc*16 +: 8]))
            else $error("capture low byte read returned the wrong value");

         a_cap_high_store: assert property (
            @(posedge clk_i) disable iff (srst_i)
            sfr_wr_i && cap_high_hit[gc] && !auto_reload_select_i |=>
               cap_values[gc*16+8 +: 8] == $past(sfr_wdata_i))
            else $error("capture high byte write not stored");

         a_cap_high_read: assert property (
            @(posedge clk_i) disable iff (srst_i)
            sfr_rd_i && cap_high_hit[gc] && !auto_reload_select_i |=>
               sfr_rdata_o == $past(cap_values[gc*16+8 +: 8]))
            else $error("capture high byte read returned the wrong value");

         a_reload_high_write: assert property (
            @(posedge clk_i) disable iff (srst_i)
            sfr_wr_i && cap_high_hit[gc] && auto_reload_select_i |=>
               reload_values[gc*16+8 +: 8] == $past(sfr_wdata_i) &&
               cap_values[gc*16 +: 16] == $past(cap_values[gc*16 +: 16]))
            else $error("reload select did not redirect the high byte write");

         a_reload_read: assert property (
            @(posedge clk_i) disable iff (srst_i)
            sfr_rd_i && cap_low_hit[gc] && auto_reload_select_i |=>
               sfr_rdata_o == $past(reload_values[gc*16 +: 8]))
            else $error("reload select did not steer the low byte read");

         a_low_clears_each: assert property (
            @(posedge clk_i) disable iff (srst_i)
            sfr_wr_i && cap_low_hit[gc] && (gc != pca_regs_pkg::WATCHDOG_CHANNEL || !watchdog_enable_i) |=>
               !ecom[gc])
            else $error("low byte write did not clear the module enable");

         a_high_sets_each: assert property (
            @(posedge clk_i) disable iff (srst_i)
            sfr_wr_i && cap_high_hit[gc] && (gc != pca_regs_pkg::WATCHDOG_CHANNEL || !watchdog_enable_i) |=>
               ecom[gc])
            else $error("high byte write did not set the module enable");

         a_enable_sw_only: assert property (
            @(posedge clk_i) disable iff (srst_i)
            !(sfr_wr_i && (cap_low_hit[gc] || cap_high_hit[gc])) |=> $stable(ecom[gc]))
            else $error("module enable changed without a capture byte write");

         a_match_each: assert property (
            @(posedge clk_i) disable iff (srst_i)
            ecom[gc] && count == cap_values[gc*16 +: 16] |=> match[gc])
            else $error("enabled module missed a counter match");

         a_no_match_each: assert property (
            @(posedge clk_i) disable iff (srst_i)
            !ecom[gc] |=> !match[gc])
            else $error("disabled module reported a match");
      end
   endgenerate

endmodule

// ---- dv/test_pca_counter_capture_regs.sv ----
// self-checking bench for the counter array register block.
// assumes the package and design files under verilog/ are compiled first.
`timescale 1ns/1ps

module test_pca_counter_capture_regs;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] sfr_addr_i = 8'h00;
   logic sfr_wr_i = 1'b0;
   logic sfr_rd_i = 1'b0;
   logic [7:0] sfr_wdata_i = 8'h00;
   logic watchdog_enable_i = 1'b0;
   logic auto_reload_select_i = 1'b0;
   logic count_run_i = 1'b0;
   logic [7:0] sfr_rdata_o;
   logic sfr_rvalid_o;
   logic [15:0] array_counter_o;
   logic [5:0] comparator_function_enable_o;
   logic [5:0] match_o;
   logic [95:0] reload_value_o;
   int n_fail = 0;
   int checked = 0;
   logic [7:0] exp_q[$];
   logic [15:0] cap [6];
   logic [5:0] en;
   logic [15:0] r;
   int seed;
   int m;
   int k;

   always #5 clk_i = ~clk_i;

   pca_counter_capture_regs i_pca_counter_capture_regs (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .sfr_addr_i(sfr_addr_i),
      .sfr_wr_i(sfr_wr_i),
      .sfr_rd_i(sfr_rd_i),
      .sfr_wdata_i(sfr_wdata_i),
      .watchdog_enable_i(watchdog_enable_i),
      .auto_reload_select_i(auto_reload_select_i),
      .count_run_i(count_run_i),
      .sfr_rdata_o(sfr_rdata_o),
      .sfr_rvalid_o(sfr_rvalid_o),
      .array_counter_o(array_counter_o),
      .comparator_function_enable_o(comparator_function_enable_o),
      .match_o(match_o),
      .reload_value_o(reload_value_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   function automatic logic [7:0] lo_a(input int i);
      return pca_regs_pkg::CAP_LOW_ADDRS[8*i +: 8];
   endfunction

   function automatic logic [7:0] hi_a(input int i);
      return pca_regs_pkg::CAP_HIGH_ADDRS[8*i +: 8];
   endfunction

   // strobe is lowered a full cycle later, so back-to-back calls never collide
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      @(negedge clk_i);
      sfr_wr_i = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk_i);
      sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      exp_q.push_back(e);
      @(negedge clk_i);
      sfr_rd_i = 1'b0;
   endtask

   task automatic chk_en(input string what);
      check(what, {10'h000, comparator_function_enable_o}, {10'h000, en});
   endtask

   // read data is judged only when the block flags it valid
   always @(posedge clk_i) begin
      if (sfr_rvalid_o === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("unexpected_rvalid", 16'h0001, 16'h0000);
         end else begin
            check("rdata", {8'h00, sfr_rdata_o}, {8'h00, exp_q.pop_front()});
         end
      end
   end

   initial begin
      #100us;
      n_fail++;
      $display("timeout waiting for the tests");
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = $urandom(32'h609b7d29);
      repeat (2) @(negedge clk_i);
      srst_i = 1'b0;
      for (m = 0; m < 6; m++) begin
         rd(lo_a(m), 8'h00);
         rd(hi_a(m), 8'h00);
      end
      rd(8'hF9, 8'h00);
      rd(8'hFA, 8'h00);
      rd(8'h10, pca_regs_pkg::UNMAPPED_READ);
      en = 6'h00;
      chk_en("enable_reset");
      $display("test reset values done");

      for (m = 0; m < 6; m++) begin
         cap[m] = 16'($urandom());
         wr(hi_a(m), cap[m][15:8]);
         en[m] = 1'b1;
         chk_en("enable_set");
         wr(lo_a(m), cap[m][7:0]);
         en[m] = 1'b0;
         chk_en("enable_clear");
         wr(hi_a(m), cap[m][15:8]);
         en[m] = 1'b1;
         chk_en("enable_set_again");
         rd(lo_a(m), cap[m][7:0]);
         rd(hi_a(m), cap[m][15:8]);
      end
      $display("test capture bytes done");

      // module 5 keeps its enable and the counter ignores writes while locked
      watchdog_enable_i = 1'b1;
      wr(lo_a(5), 8'h5A);
      chk_en("enable5_locked");
      wr(8'hF9, 8'hAA);
      wr(8'hFA, 8'hBB);
      check("counter_locked", array_counter_o, 16'h0000);
      rd(8'hF9, 8'h00);
      watchdog_enable_i = 1'b0;
      cap[5][7:0] = 8'h5A;
      rd(lo_a(5), cap[5][7:0]);
      wr(8'hF9, 8'hFE);
      wr(8'hFA, 8'h12);
      check("counter_write", array_counter_o, 16'h12FE);
      $display("test watchdog lock done");

      // low read while running freezes the high byte of that same sample
      count_run_i = 1'b1;
      rd(8'hF9, 8'hFF);
      rd(8'hFA, 8'h12);
      count_run_i = 1'b0;
      check("counter_run", array_counter_o, 16'h1302);
      rd(8'hF9, 8'h02);
      rd(8'hFA, 8'h13);
      $display("test snapshot done");

      auto_reload_select_i = 1'b1;
      for (m = 0; m < 6; m++) begin
         r = 16'($urandom());
         wr(lo_a(m), r[7:0]);
         wr(hi_a(m), r[15:8]);
         check("reload", reload_value_o[16*m +: 16], r);
         rd(lo_a(m), r[7:0]);
         rd(hi_a(m), r[15:8]);
      end
      auto_reload_select_i = 1'b0;
      for (m = 0; m < 6; m++) begin
         rd(lo_a(m), cap[m][7:0]);
         rd(hi_a(m), cap[m][15:8]);
      end
      $display("test reload select done");

      wr(lo_a(0), 8'h08);
      wr(hi_a(0), 8'h13);
      count_run_i = 1'b1;
      k = 0;
      while (match_o[0] !== 1'b1 && k < 40) begin
         @(negedge clk_i);
         k++;
      end
      count_run_i = 1'b0;
      check("match_moment", array_counter_o, 16'h1309);
      wr(lo_a(0), 8'h0C);
      count_run_i = 1'b1;
      k = 0;
      repeat (10) begin
         @(negedge clk_i);
         if (match_o[0] !== 1'b0) begin
            k++;
         end
      end
      count_run_i = 1'b0;
      check("match_disabled", 16'(k), 16'h0000);
      $display("test compare done");

      repeat (4) @(negedge clk_i);
      check("reads_pending", 16'(exp_q.size()), 16'h0000);
      wrap_up();
   end
endmodule
